// ==== hdl/block_send_map.svh ====
// constants for the triggered block send controller
// assumes a 25 MHz clock and byte-wide register data
`ifndef BLOCK_SEND_MAP_SVH
`define BLOCK_SEND_MAP_SVH

// longest block that one send may carry
`define MAX_LEN 248
// send timeout and clock rate
`define TX_TIMEOUT_MS 2000
`define CLK_FREQ_KHZ 25000

// result byte fields
`define RES_BAD_PORT 0
`define RES_TIMEOUT 1
`define RES_BAD_LEN 2
`define RES_PORT_BUSY 3
`define RES_SEND_ERR 4
`define RES_DONE 7

// register offsets
`define REG_CTRL 4'h0
`define REG_RESULT 4'h1
`define REG_STATUS 4'h2
`define REG_MASK 4'h3

// control and status fields
`define CTRL_ENABLE 0
`define STAT_DONE 0
`define STAT_FAULT 1
`define CTRL_RESET 8'h00
`define MASK_RESET 8'h00

`endif

// ==== hdl/block_send_pkg.sv ====
// types shared by the block send controller and its bench
// assumes the constants header is compiled alongside
package block_send_pkg;

  // one send request as the program logic presents it
  typedef struct packed {
    logic [7:0] port;
    logic [15:0] addr;
    logic [15:0] count;
  } req_t;

  // gray-coded along idle, check, fetch, load, send
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CHECK = 3'h1,
    ST_FETCH = 3'h3,
    ST_LOAD = 3'h2,
    ST_SEND = 3'h6
  } state_t;

endpackage

// ==== hdl/block_send_op.sv ====
// triggered block send: fetches bytes from memory, hands them to
// a numbered serial port and reports the outcome in a result byte
// assumes memory, ports and program logic all run on clk
//
// The placing of the registers and the strobed register port were left to the implementer.
`include "block_send_map.svh"

module block_send_op #(
  parameter int NUM_PORTS = 3,
  parameter int MAX_LEN = `MAX_LEN,
  parameter int TIMEOUT_CYC = `TX_TIMEOUT_MS * `CLK_FREQ_KHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic trigger_in,
  input block_send_pkg::req_t req,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic [NUM_PORTS-1:0] tx_valid,
  output logic [7:0] tx_data,
  input wire logic [NUM_PORTS-1:0] tx_ready,
  input wire logic [NUM_PORTS-1:0] tx_err,
  input wire logic [NUM_PORTS-1:0] port_busy,
  output logic [7:0] result_byte,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////
  // state
  block_send_pkg::state_t state, next_state;
  block_send_pkg::req_t req_q, next_req_q;
  logic trig_q;
  logic [7:0] idx, next_idx;
  logic [31:0] tmr, next_tmr;
  logic [7:0] next_result_byte, next_tx_data;
  logic [NUM_PORTS-1:0] next_tx_valid, sel;
  logic [15:0] next_mem_addr;
  logic next_mem_rd;
  logic ev_done, ev_fault;
  logic ctrl_en, next_ctrl_en;
  logic [1:0] status, next_status, mask, next_mask;
  logic [7:0] next_rdata;
  logic next_irq;
  logic trig_edge, port_ok, len_ok, sel_ready, sel_err, sel_busy;

  // one select line per port, decoded from the plain index
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_sel
      assign sel[gi] = (req_q.port == 8'(gi));
    end
  endgenerate

  assign sel_ready = |(tx_ready & sel);
  assign sel_err = |(tx_err & sel);
  assign sel_busy = |(port_busy & sel);
  assign trig_edge = trigger_in & ~trig_q;
  assign port_ok = (req_q.port < 8'(NUM_PORTS));
  // a negative count has bit 15 set and so also fails the upper bound
  assign len_ok = (req_q.count != 16'h0000) &&
                  (req_q.count <= 16'(MAX_LEN));

  ////////////////////////////////////////////////////////////////////
  // sequencer: every exit from a busy state writes bit 7
  always_comb begin
    next_state = state;
    next_req_q = req_q;
    next_idx = idx;
    next_tmr = tmr;
    next_result_byte = result_byte;
    next_tx_data = tx_data;
    next_tx_valid = tx_valid;
    next_mem_addr = mem_addr;
    next_mem_rd = 1'b0;
    ev_done = 1'b0;
    ev_fault = 1'b0;
    if (state != block_send_pkg::ST_IDLE) begin
      next_tmr = tmr + 32'h1;
    end
    case (state)
      block_send_pkg::ST_IDLE: begin
        // edges arriving while a send runs are not queued
        if (trig_edge && ctrl_en) begin
          next_req_q = req;
          next_result_byte = 8'h00;
          next_tmr = 32'h0;
          next_idx = 8'h00;
          next_state = block_send_pkg::ST_CHECK;
        end
      end
      block_send_pkg::ST_CHECK: begin
        next_state = block_send_pkg::ST_IDLE;
        ev_done = 1'b1;
        ev_fault = 1'b1;
        next_result_byte[`RES_DONE] = 1'b1;
        if (!port_ok) begin
          next_result_byte[`RES_BAD_PORT] = 1'b1;
        end else if (!len_ok) begin
          next_result_byte[`RES_BAD_LEN] = 1'b1;
        end else if (sel_busy) begin
          // receive in progress blocks a send on a half-duplex port
          next_result_byte[`RES_PORT_BUSY] = 1'b1;
        end else begin
          ev_done = 1'b0;
          ev_fault = 1'b0;
          next_result_byte[`RES_DONE] = 1'b0;
          next_mem_addr = req_q.addr;
          next_mem_rd = 1'b1;
          next_state = block_send_pkg::ST_FETCH;
        end
      end
      block_send_pkg::ST_FETCH: begin
        next_state = block_send_pkg::ST_LOAD;
      end
      block_send_pkg::ST_LOAD: begin
        next_tx_data = mem_rdata;
        next_tx_valid = sel;
        next_state = block_send_pkg::ST_SEND;
      end
      block_send_pkg::ST_SEND: begin
        if (sel_ready) begin
          next_tx_valid = '0;
          next_idx = idx + 8'h01;
          if (16'(next_idx) == req_q.count) begin
            ev_done = 1'b1;
            next_result_byte[`RES_DONE] = 1'b1;
            next_state = block_send_pkg::ST_IDLE;
          end else begin
            // ascending addresses, one byte per handshake
            next_mem_addr = mem_addr + 16'h0001;
            next_mem_rd = 1'b1;
            next_state = block_send_pkg::ST_FETCH;
          end
        end
      end
      default: begin
        next_state = block_send_pkg::ST_IDLE;
      end
    endcase
    // a port fault outranks the timeout, which outranks completion
    if (state == block_send_pkg::ST_SEND && sel_err) begin
      next_tx_valid = '0;
      next_mem_rd = 1'b0;
      ev_done = 1'b1;
      ev_fault = 1'b1;
      next_result_byte = 8'h00;
      next_result_byte[`RES_SEND_ERR] = 1'b1;
      next_result_byte[`RES_DONE] = 1'b1;
      next_state = block_send_pkg::ST_IDLE;
    end else if (state != block_send_pkg::ST_IDLE &&
                 state != block_send_pkg::ST_CHECK &&
                 tmr >= 32'(TIMEOUT_CYC - 1)) begin
      next_tx_valid = '0;
      next_mem_rd = 1'b0;
      ev_done = 1'b1;
      ev_fault = 1'b1;
      next_result_byte = 8'h00;
      next_result_byte[`RES_TIMEOUT] = 1'b1;
      next_result_byte[`RES_DONE] = 1'b1;
      next_state = block_send_pkg::ST_IDLE;
    end
  end

  // registers of the sequencer, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= block_send_pkg::ST_IDLE;
      req_q <= '0;
      trig_q <= 1'b1; // a level high out of reset is not an edge
      idx <= 8'h00;
      tmr <= 32'h0;
      result_byte <= 8'h00;
      tx_data <= 8'h00;
      tx_valid <= '0;
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      req_q <= next_req_q;
      trig_q <= trigger_in;
      idx <= next_idx;
      tmr <= next_tmr;
      result_byte <= next_result_byte;
      tx_data <= next_tx_data;
      tx_valid <= next_tx_valid;
      mem_addr <= next_mem_addr;
      mem_rd <= next_mem_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register port: status bits are sticky, a read of REG_STATUS clears them
  always_comb begin
    next_ctrl_en = ctrl_en;
    next_mask = mask;
    next_status = status;
    next_rdata = 8'h00;
    if (wr && addr == `REG_CTRL) begin
      next_ctrl_en = wdata[`CTRL_ENABLE];
    end
    if (wr && addr == `REG_MASK) begin
      next_mask = wdata[1:0];
    end
    if (rd) begin
      case (addr)
        `REG_CTRL: next_rdata = {7'h00, ctrl_en};
        `REG_RESULT: next_rdata = result_byte;
        `REG_STATUS: next_rdata = {6'h00, status};
        `REG_MASK: next_rdata = {6'h00, mask};
        default: next_rdata = 8'h00;
      endcase
      if (addr == `REG_STATUS) begin
        next_status = 2'b00;
      end
    end
    // a new event in the clearing cycle survives the read
    if (ev_done) begin
      next_status[`STAT_DONE] = 1'b1;
    end
    if (ev_fault) begin
      next_status[`STAT_FAULT] = 1'b1;
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en <= 1'(`CTRL_RESET);
      mask <= 2'(`MASK_RESET);
      status <= 2'b00;
      rdata <= 8'h00;
      irq <= 1'b0;
    end else if (ce) begin
      ctrl_en <= next_ctrl_en;
      mask <= next_mask;
      status <= next_status;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_edge_starts: assert property (
    ce && state == block_send_pkg::ST_IDLE && trigger_in && !trig_q
    && ctrl_en |=> state == block_send_pkg::ST_CHECK)
    else $error("trigger edge did not start a send");
  a_level_no_start: assert property (
    ce && state == block_send_pkg::ST_IDLE && (trig_q || !ctrl_en)
    |=> state == block_send_pkg::ST_IDLE)
    else $error("send started without an enabled edge");
  a_bad_port: assert property (
    ce && state == block_send_pkg::ST_CHECK && !port_ok
    |=> result_byte == 8'h81 && tx_valid == '0)
    else $error("bad port not reported");
  a_bad_len: assert property (
    ce && state == block_send_pkg::ST_CHECK && port_ok
    && (req_q.count == 16'h0 || req_q.count > 16'(MAX_LEN))
    |=> result_byte == 8'h84)
    else $error("bad length not reported");
  a_port_busy: assert property (
    ce && state == block_send_pkg::ST_CHECK && port_ok && len_ok
    && sel_busy |=> result_byte == 8'h88)
    else $error("busy port not reported");
  a_clear_start: assert property (
    state == block_send_pkg::ST_CHECK |-> result_byte == 8'h00)
    else $error("result not cleared at start");
  a_done_low: assert property (
    state != block_send_pkg::ST_IDLE |-> !result_byte[7])
    else $error("done bit high while running");
  a_send_fault: assert property (
    ce && state == block_send_pkg::ST_SEND && sel_err
    |=> result_byte == 8'h90 && tx_valid == '0
    && state == block_send_pkg::ST_IDLE)
    else $error("send fault not handled");
  a_timeout_hit: assert property (
    ce && state != block_send_pkg::ST_IDLE
    && state != block_send_pkg::ST_CHECK && !sel_err
    && tmr >= 32'(TIMEOUT_CYC - 1) |=> result_byte == 8'h82)
    else $error("timeout not reported");
  a_reserved_zero: assert property (
    result_byte[6:5] == 2'b00)
    else $error("reserved result bits set");
  a_fetch_addr: assert property (
    state == block_send_pkg::ST_FETCH
    |-> mem_rd && mem_addr == req_q.addr + 16'(idx))
    else $error("fetch address out of sequence");

  c_good_send: cover property (
    state == block_send_pkg::ST_SEND && sel_ready
    ##1 result_byte == 8'h80);
  c_bad_len: cover property (result_byte == 8'h84);
  c_timeout: cover property (result_byte == 8'h82);
  c_irq: cover property (irq && rd && addr == `REG_STATUS);

endmodule

// ==== tb/send_partner.sv ====
// memory and serial port model facing the block send controller
// assumes one clock and one read strobe per fetched byte
module send_partner (
  input wire logic clk,
  input wire logic slow,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata,
  input wire logic [2:0] tx_valid,
  output logic [2:0] tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt = 3'h0;
  initial mem_rdata = 8'h00;
  ////////////////////////////////////////////////////////////////////////
  // data only in the cycle after the strobe, else a changing pattern
  always @(posedge clk) begin
    cnt <= cnt + 3'h1;
    if (mem_rd) mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5A;
    else mem_rdata <= ~mem_rdata;
  end
  // a slow port takes a byte in one cycle of eight, so long sends stall
  assign tx_ready = (slow && cnt != 3'h0) ? 3'h0 : 3'h7;
endmodule

// ==== tb/test_block_send_op.sv ====
// self-checking bench for the triggered block send controller
// assumes the partner model stands for memory and the serial ports
`include "block_send_map.svh"
module test_block_send_op;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO = 1000;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic trigger_in = 1'b0, slow = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [2:0] tx_err = 3'h0, port_busy = 3'h0;
  block_send_pkg::req_t req = '0;
  logic [15:0] mem_addr;
  logic mem_rd, irq;
  logic [7:0] mem_rdata, tx_data, result_byte, rdata, p;
  logic [2:0] tx_valid, tx_ready;
  logic [7:0] got[$];
  logic [2:0] gotv[$];
  int fails = 0, cmp_count = 0, seed = 59143, cyc;
  always #20 clk = ~clk;
  block_send_op #(.TIMEOUT_CYC(TO)) u_dut (.clk(clk), .rst_n(rst_n),
    .ce(ce), .trigger_in(trigger_in), .req(req), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .tx_err(tx_err),
    .port_busy(port_busy), .result_byte(result_byte), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  send_partner u_far (.clk(clk), .slow(slow), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  ////////////////////////////////////////////////////////////////////////
  // every byte the port accepts, with the port that took it
  always @(posedge clk) if (|(tx_valid & tx_ready)) begin
    got.push_back(tx_data);
    gotv.push_back(tx_valid);
  end
  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
      input string msg);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s %h not %h", $time, msg, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // register bus: one-cycle strobes, read data in the following cycle
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
      input string m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e, m);
  endtask
  // one triggered send; trigger stays high after completion and, for a send that passes the check, a second
  // edge arrives mid-run, neither of which may start another send
  task automatic send(input logic [7:0] pt, input logic [15:0] a,
      input logic [15:0] n, input logic [7:0] e);
    @(posedge clk);
    got.delete();
    gotv.delete();
    req <= '{port: pt, addr: a, count: n};
    trigger_in <= 1'b1;
    @(posedge clk);
    #1 chk(result_byte, 8'h00, "result at start");
    for (cyc = 1; cyc < 3000; cyc++) begin
      @(posedge clk);
      if (cyc == 2) trigger_in <= 1'b0;
      if (cyc == 3) trigger_in <= 1'b1;
      #1;
      if (result_byte[7] === 1'b1) break;
    end
    if (cyc == 3000) begin
      fails++;
      give_verdict();
    end
    chk(result_byte, e, "result at end");
    repeat (5) @(posedge clk);
    #1 chk(result_byte, e, "result held");
    chk(tx_valid, 3'h0, "port idle after end");
    trigger_in <= 1'b0;
    if ((e & 8'h0D) != 8'h00) chk(got.size(), 0, "refused sent");
    if (e == 8'h80) begin
      chk(got.size(), n, "byte total");
      foreach (got[i]) begin
        chk(got[i], exp_byte(a + 16'(i)), "byte");
        chk(gotv[i], 3'h1 << pt, "port");
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(result_byte, 8'h00, "reset result");
    chk(irq, 1'b0, "reset irq");
    rd_chk(`REG_MASK, `MASK_RESET, "mask reset");
    rd_chk(`REG_CTRL, `CTRL_RESET, "ctrl reset");
    // an edge while disabled does nothing
    req <= '{port: 8'h00, addr: 16'h0100, count: 16'h0001};
    trigger_in <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(got.size(), 0, "send while disabled");
    trigger_in <= 1'b0;
    wr_reg(`REG_MASK, 8'h03);
    wr_reg(`REG_CTRL, 8'h01);
    for (int k = 0; k < 8; k++) begin
      slow <= 1'($random(seed));
      p = 8'($unsigned($random(seed)) % 3);
      send(p, 16'($random(seed)), 16'(1 + $unsigned($random(seed)) % 6),
        8'h80);
    end
    slow <= 1'b0;
    send(8'h00, 16'h2000, 16'h00F8, 8'h80);
    chk(irq, 1'b1, "irq on done");
    rd_chk(`REG_STATUS, 8'h01, "status done");
    rd_chk(`REG_STATUS, 8'h00, "status cleared");
    chk(irq, 1'b0, "irq cleared");
    send(8'h03, 16'h0010, 16'h0000, 8'h81);
    send(8'h01, 16'h0010, 16'h0000, 8'h84);
    send(8'h01, 16'h0010, 16'h00F9, 8'h84);
    port_busy <= 3'h4;
    send(8'h02, 16'h0020, 16'h0003, 8'h88);
    send(8'h00, 16'h0030, 16'h0002, 8'h80);
    port_busy <= 3'h0;
    tx_err <= 3'h2;
    send(8'h01, 16'h0040, 16'h0008, 8'h90);
    send(8'h00, 16'h0050, 16'h0003, 8'h80);
    tx_err <= 3'h0;
    slow <= 1'b1;
    send(8'h00, 16'h3000, 16'h00F8, 8'h82);
    chk(cyc >= TO - 3 && cyc <= TO + 3, 1'b1, "timeout moment");
    slow <= 1'b0;
    chk(irq, 1'b1, "irq on fault");
    rd_chk(`REG_STATUS, 8'h03, "status both");
    wr_reg(`REG_MASK, 8'h00);
    send(8'h05, 16'h0060, 16'h0001, 8'h81);
    chk(irq, 1'b0, "irq masked");
    rd_chk(`REG_RESULT, 8'h81, "result register");
    rd_chk(4'h9, 8'h00, "unmapped read");
    // ce low: neither the write nor the trigger pulse may be taken
    ce <= 1'b0;
    req <= '{port: 8'h00, addr: 16'h0070, count: 16'h0001};
    trigger_in <= 1'b1;
    wr_reg(`REG_CTRL, 8'h00);
    trigger_in <= 1'b0;
    @(posedge clk) ce <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(result_byte, 8'h81, "send while frozen");
    rd_chk(`REG_CTRL, 8'h01, "write while frozen");
    give_verdict();
  end
endmodule
